// >>> hdl/dual_eeprom_pkg.sv
// Constants and types shared by the dual mode serial EEPROM controller.
//
// Overview of operation
// - Select byte: type field in b7..b4, three ignored bits, read flag b0, MSB first.
// - After power-up start in transmit-only mode, shifting data on link clock rising edges.
// - A falling serial clock edge moves transmit-only mode into bidirectional slave mode.
// - Without error recovery, bidirectional mode holds until power is cycled.
// - With error recovery, enter a transition state that may fall back to transmit-only.
// - Transition falls back after 128 link pulses or timeout; serial clock falls restart both.
// - A valid select byte locks bidirectional mode; link clock then cannot disturb reads.
// - Host gives nine link pulses first; the data line stays released throughout.
// - The tenth link rising edge drives the top bit of location zero.
// - Each byte takes nine pulses: eight data bits MSB first, then a don't-care bit.
// - While the serial clock stays high, bytes stream with automatic address increment.
// - After the highest location the address counter wraps to zero.
// - Storage is 128 bytes of eight bits, addressed by a 7-bit counter.
// - Current read: start, select with read flag, byte at current address, write enable ignored.
// - Random read: write select, address byte, repeated start, then read select.
// - Sequential reads return 1 to 128 consecutive bytes while the host acknowledges.
// - Byte and page writes begin with a write select and execute only with write enable high.
// - Write enable comes from the link clock pin or the write control pin, per variant.
`default_nettype none
package dual_eeprom_pkg;
  localparam int unsigned ADDR_W          = 7;
  localparam int unsigned DEPTH           = 128;
  localparam int unsigned PAGE_BITS       = 3;
  localparam int unsigned SEL_TYPE_MSB    = 7;
  localparam int unsigned SEL_TYPE_LSB    = 4;
  localparam int unsigned SEL_RW_BIT      = 0;
  localparam logic [3:0]  DATA_BITS       = 4'h8;
  localparam logic [3:0]  BYTE_PULSES     = 4'h9;
  localparam logic [3:0]  INIT_PULSES     = 4'h9;
  localparam logic [3:0]  DC_BIT          = 4'h8;
  localparam logic [7:0]  PULSE_LIMIT     = 8'h80;
  localparam int unsigned RECOVERY_MS     = 2000;
  localparam int unsigned REF_CLK_KHZ     = 100000;
  localparam int unsigned RECOVERY_CYCLES = RECOVERY_MS * REF_CLK_KHZ;

  typedef enum logic [1:0] {M_TX, M_TRANS, M_I2C} mode_e;
  typedef enum logic [2:0] {S_IDLE, S_SEL, S_ADR, S_WR, S_RD} slv_e;
endpackage : dual_eeprom_pkg
`default_nettype wire

// >>> hdl/tx_link_if.sv
// Interface between the controller core and the transmit-only link logic.
`timescale 1ns/100ps
`default_nettype none
interface tx_link_if;
  logic       en;
  logic [7:0] data;
  logic       ack_t;
  logic       req_t;
  logic       pulse_t;
  logic       oe;

  modport core (output en, output data, output ack_t, input req_t, input pulse_t, input oe);
  modport link (input en, input data, input ack_t, output req_t, output pulse_t, output oe);
endinterface : tx_link_if
`default_nettype wire

// >>> hdl/tx_link.sv
// Transmit-only shifter running on the link clock.
`timescale 1ns/100ps
`default_nettype none
module tx_link
  import dual_eeprom_pkg::*;
(
  // Clock and reset
  input  wire logic link_clk_i,
  input  wire logic rst_i,
  // Core side
  tx_link_if.link   lnk
);

  typedef struct packed {
    logic       en1;
    logic       en2;
    logic       ak1;
    logic       ak2;
    logic       ak3;
    logic [3:0] init;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] nxt;
    logic       req_t;
    logic       pul_t;
    logic       oe;
  } link_s;

  logic  rs1_r;
  logic  rs2_r;
  link_s q_r;
  link_s q_nxt;

  // Reset comes from the core domain and is resynchronised before use.
  always_ff @(posedge link_clk_i) begin
    rs1_r <= rst_i;
    rs2_r <= rs1_r;
  end

  always_comb begin
    q_nxt       = q_r;
    q_nxt.en1   = lnk.en;
    q_nxt.en2   = q_r.en1;
    q_nxt.ak1   = lnk.ack_t;
    q_nxt.ak2   = q_r.ak1;
    q_nxt.ak3   = q_r.ak2;
    q_nxt.pul_t = ~q_r.pul_t;
    // The core changes data in the same cycle as it toggles the acknowledge; the acknowledge synchroniser stages give data time to settle before it is taken here.
    if (q_r.ak2 != q_r.ak3) begin
      q_nxt.nxt = lnk.data;
    end
    if (!q_r.en2) begin
      q_nxt.init = 4'h0;
      q_nxt.bitn = 4'h0;
      q_nxt.oe   = 1'b0;
    end else if (q_r.init != INIT_PULSES) begin
      q_nxt.init = q_r.init + 4'h1;
      q_nxt.oe   = 1'b0;
      if (q_r.init == 4'h0) begin
        q_nxt.req_t = ~q_r.req_t;
      end
    end else if (q_r.bitn == 4'h0) begin
      q_nxt.oe    = ~q_r.nxt[7];
      q_nxt.sh    = {q_r.nxt[6:0], 1'b1};
      q_nxt.bitn  = 4'h1;
      q_nxt.req_t = ~q_r.req_t;
    end else if (q_r.bitn == DC_BIT) begin
      q_nxt.oe   = 1'b0;
      q_nxt.bitn = 4'h0;
    end else begin
      q_nxt.oe   = ~q_r.sh[7];
      q_nxt.sh   = {q_r.sh[6:0], 1'b1};
      q_nxt.bitn = q_r.bitn + 4'h1;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (rs2_r) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign lnk.req_t   = q_r.req_t;
  assign lnk.pulse_t = q_r.pul_t;
  assign lnk.oe      = q_r.oe;

  default clocking cb @(posedge link_clk_i); endclocking
  default disable iff (rs2_r);

  sequence s_load;
    q_r.en2 && q_r.init == INIT_PULSES && q_r.bitn == 4'h0;
  endsequence

  init_quiet_a: assert property (
    q_r.en2 && q_r.init != INIT_PULSES |=> !q_r.oe)
    else $error("Data line driven during initialisation pulses.");

  first_bit_a: assert property (
    s_load |=> q_r.oe == !$past(q_r.nxt[7]) && q_r.bitn == 4'h1)
    else $error("Byte load did not drive its top bit.");

  byte_len_a: assert property (
    s_load ##1 q_r.en2 [*8] |=> q_r.bitn == 4'h0 && !q_r.oe)
    else $error("Byte did not span nine link pulses.");

endmodule : tx_link
`default_nettype wire

// >>> hdl/dual_eeprom_ctrl.sv
// Dual mode serial EEPROM controller: storage, mode control and serial slave.
`timescale 1ns/100ps
`default_nettype none
module dual_eeprom_ctrl
  import dual_eeprom_pkg::*;
#(
  parameter bit          ERR_RECOVERY = 1'b1,
  parameter bit          WE_FROM_LINK = 1'b0,
  parameter int unsigned RECOVERY_CYC = RECOVERY_CYCLES,
  // Device type field value; arbitrary, chosen for this model.
  parameter logic [3:0]  DEV_TYPE     = 4'h5
)(
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  // Transmit-only link clock
  input  wire logic       transmit_only_clock_i,
  // Serial bus pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output var  logic       sda_o,
  output var  logic       sda_oe_o,
  // Write control pin
  input  wire logic       write_protect_input_i,
  // Status
  output var  logic       tx_mode_o,
  output var  logic       locked_o
);

  localparam int unsigned TMR_W = $clog2(RECOVERY_CYC + 1);

  typedef struct packed {
    logic              scl1;
    logic              scl2;
    logic              scl3;
    logic              sda1;
    logic              sda2;
    logic              sda3;
    logic              we1;
    logic              we2;
    logic              rq1;
    logic              rq2;
    logic              rq3;
    logic              pl1;
    logic              pl2;
    logic              pl3;
    mode_e             mode;
    slv_e              sl;
    logic [3:0]        cnt;
    logic [7:0]        sh;
    logic              rw;
    logic              mack;
    logic              oe;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        txd;
    logic              ak_t;
    logic [7:0]        pcnt;
    logic [TMR_W-1:0]  tmr;
  } core_s;

  core_s             q_r;
  core_s             q_nxt;
  logic [7:0]        mem_r [DEPTH];
  logic [7:0]        rd_byte;
  logic              wr_en;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_c;
  logic              stop_c;
  logic              req_c;
  logic              pulse_c;
  logic              rd_load;

  tx_link_if lnk ();

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
    page_inc = {a[ADDR_W-1:PAGE_BITS], a[PAGE_BITS-1:0] + PAGE_BITS'(1)};
  endfunction : page_inc

  function automatic logic toggled(input logic now, input logic prev);
    toggled = now ^ prev;
  endfunction : toggled

  ////////////////////////////////////////////////////////////////////////////////
  // Pin events, all taken from the second and third synchroniser stages.

  assign scl_rise = q_r.scl2 & ~q_r.scl3;
  assign scl_fall = ~q_r.scl2 & q_r.scl3;
  assign start_c  = q_r.scl2 & q_r.scl3 & q_r.sda3 & ~q_r.sda2;
  assign stop_c   = q_r.scl2 & q_r.scl3 & ~q_r.sda3 & q_r.sda2;
  assign req_c    = toggled(q_r.rq2, q_r.rq3);
  assign pulse_c  = toggled(q_r.pl2, q_r.pl3);
  assign rd_byte  = mem_r[q_r.addr];
  assign rd_load  = (q_r.sl == S_SEL && q_r.rw) || (q_r.sl == S_RD && q_r.mack);

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    q_nxt      = q_r;
    wr_en      = 1'b0;
    q_nxt.scl1 = scl_i;
    q_nxt.scl2 = q_r.scl1;
    q_nxt.scl3 = q_r.scl2;
    q_nxt.sda1 = sda_i;
    q_nxt.sda2 = q_r.sda1;
    q_nxt.sda3 = q_r.sda2;
    q_nxt.we1  = WE_FROM_LINK ? transmit_only_clock_i : write_protect_input_i;
    q_nxt.we2  = q_r.we1;
    q_nxt.rq1  = lnk.req_t;
    q_nxt.rq2  = q_r.rq1;
    q_nxt.rq3  = q_r.rq2;
    q_nxt.pl1  = lnk.pulse_t;
    q_nxt.pl2  = q_r.pl1;
    q_nxt.pl3  = q_r.pl2;

    // Serial slave, active in the transition state and in locked mode.
    if (q_r.mode != M_TX) begin
      if (start_c) begin
        q_nxt.sl  = S_SEL;
        q_nxt.cnt = 4'h0;
        q_nxt.oe  = 1'b0;
      end else if (stop_c) begin
        q_nxt.sl = S_IDLE;
        q_nxt.oe = 1'b0;
      end else if (q_r.sl != S_IDLE && scl_rise) begin
        if (q_r.cnt < DATA_BITS && q_r.sl != S_RD) begin
          q_nxt.sh = {q_r.sh[6:0], q_r.sda2};
        end
        if (q_r.cnt == DATA_BITS) begin
          q_nxt.mack = ~q_r.sda2;
        end
        q_nxt.cnt = q_r.cnt + 4'h1;
      end else if (q_r.sl != S_IDLE && scl_fall) begin
        if (q_r.cnt == DATA_BITS) begin
          q_nxt.oe = 1'b1;
          case (q_r.sl)
            S_SEL: begin
              if (q_r.sh[SEL_TYPE_MSB:SEL_TYPE_LSB] == DEV_TYPE) begin
                q_nxt.rw   = q_r.sh[SEL_RW_BIT];
                q_nxt.mode = M_I2C;
              end else begin
                q_nxt.oe = 1'b0;
                q_nxt.sl = S_IDLE;
              end
            end
            S_ADR: begin
              q_nxt.addr = q_r.sh[ADDR_W-1:0];
            end
            S_WR: begin
              if (q_r.we2) begin
                wr_en      = 1'b1;
                q_nxt.addr = page_inc(q_r.addr);
              end
            end
            S_RD: begin
              q_nxt.oe = 1'b0;
            end
            default: begin
              q_nxt.sl = S_IDLE;
            end
          endcase
        end else if (q_r.cnt == BYTE_PULSES) begin
          q_nxt.cnt = 4'h0;
          q_nxt.oe  = 1'b0;
          case (q_r.sl)
            S_SEL: begin
              q_nxt.sl = q_r.rw ? S_RD : S_ADR;
            end
            S_ADR: begin
              q_nxt.sl = S_WR;
            end
            S_WR: begin
              q_nxt.sl = S_WR;
            end
            S_RD: begin
              q_nxt.sl = q_r.mack ? S_RD : S_IDLE;
            end
            default: begin
              q_nxt.sl = S_IDLE;
            end
          endcase
          // A read byte is fetched at the current address, which then advances.
          if (rd_load) begin
            q_nxt.sh   = rd_byte;
            q_nxt.addr = ADDR_W'(q_r.addr + 1'b1);
            q_nxt.oe   = ~rd_byte[7];
          end
        end else if (q_r.sl == S_RD) begin
          q_nxt.oe = ~q_r.sh[3'(4'h7 - q_r.cnt)];
        end
      end
    end

    // Mode control.
    case (q_r.mode)
      M_TX: begin
        if (req_c) begin
          q_nxt.txd  = rd_byte;
          q_nxt.addr = ADDR_W'(q_r.addr + 1'b1);
          q_nxt.ak_t = ~q_r.ak_t;
        end
        if (scl_fall) begin
          q_nxt.mode = ERR_RECOVERY ? M_TRANS : M_I2C;
          q_nxt.pcnt = 8'h00;
          q_nxt.tmr  = '0;
          q_nxt.sl   = S_IDLE;
          q_nxt.cnt  = 4'h0;
          q_nxt.oe   = 1'b0;
        end
      end
      M_TRANS: begin
        if (scl_fall) begin
          q_nxt.pcnt = 8'h00;
          q_nxt.tmr  = '0;
        end else if (q_r.pcnt == PULSE_LIMIT || q_r.tmr == TMR_W'(RECOVERY_CYC - 1)) begin
          q_nxt.mode = M_TX;
          q_nxt.sl   = S_IDLE;
          q_nxt.oe   = 1'b0;
        end else begin
          if (pulse_c) begin
            q_nxt.pcnt = q_r.pcnt + 8'h01;
          end
          q_nxt.tmr = q_r.tmr + TMR_W'(1);
        end
      end
      M_I2C: begin
        q_nxt.mode = M_I2C;
      end
      default: begin
        q_nxt.mode = M_TX;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State and storage registers.

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Storage has no reset; its content survives a reset of the control state.
  always_ff @(posedge ref_clk_i) begin
    if (wr_en) begin
      mem_r[q_r.addr] <= q_r.sh;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link logic and outputs.

  assign lnk.en    = (q_r.mode == M_TX);
  assign lnk.data  = q_r.txd;
  assign lnk.ack_t = q_r.ak_t;

  tx_link u_link (
    .link_clk_i (transmit_only_clock_i),
    .rst_i      (rst_i),
    .lnk        (lnk.link)
  );

  assign sda_o     = 1'b0;
  assign sda_oe_o  = (q_r.mode == M_TX) ? lnk.oe : q_r.oe;
  assign tx_mode_o = (q_r.mode == M_TX);
  assign locked_o  = (q_r.mode == M_I2C);

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_sel_done;
    q_r.sl == S_SEL && scl_fall && q_r.cnt == DATA_BITS;
  endsequence

  sequence s_sel_match;
    s_sel_done and (q_r.sh[SEL_TYPE_MSB:SEL_TYPE_LSB] == DEV_TYPE);
  endsequence

  sequence s_rd_first;
    q_r.sl == S_SEL && q_r.rw && scl_fall && q_r.cnt == BYTE_PULSES && q_r.mode != M_TX;
  endsequence

  tx_exit_a: assert property (
    q_r.mode == M_TX && scl_fall |=> q_r.mode != M_TX)
    else $error("Serial clock fall did not leave transmit-only mode.");

  lock_hold_a: assert property (
    q_r.mode == M_I2C |=> q_r.mode == M_I2C [*8])
    else $error("Locked mode was left.");

  trans_enter_a: assert property (
    ERR_RECOVERY && q_r.mode == M_TX && scl_fall |=> q_r.mode == M_TRANS && q_r.pcnt == 8'h00)
    else $error("Transition state not entered.");

  trans_expire_a: assert property (
    q_r.mode == M_TRANS && q_r.pcnt == PULSE_LIMIT && !scl_fall |=> q_r.mode == M_TX)
    else $error("Transition state did not expire after the pulse limit.");

  trans_restart_a: assert property (
    q_r.mode == M_TRANS && scl_fall |=> q_r.pcnt == 8'h00 && q_r.tmr == '0)
    else $error("Serial clock fall did not restart the recovery counters.");

  sel_lock_a: assert property (
    s_sel_match |=> q_r.mode == M_I2C && q_r.oe)
    else $error("Valid select byte did not lock and acknowledge.");

  sel_miss_a: assert property (
    s_sel_done and (q_r.sh[SEL_TYPE_MSB:SEL_TYPE_LSB] != DEV_TYPE) |=> q_r.sl == S_IDLE && !q_r.oe)
    else $error("Foreign select byte was answered.");

  rd_first_a: assert property (
    s_rd_first |=> q_r.sl == S_RD && q_r.oe == !q_r.sh[7] && q_r.addr == $past(q_r.addr) + 7'h01)
    else $error("Read did not start at the current address.");

  tx_wrap_a: assert property (
    q_r.mode == M_TX && req_c && q_r.addr == 7'h7F |=> q_r.addr == 7'h00 ##1 q_r.addr == 7'h00)
    else $error("Address did not wrap after the top location.");

  tx_stream_a: assert property (
    q_r.mode == M_TX && req_c |=> q_r.ak_t != $past(q_r.ak_t) && q_r.txd == $past(rd_byte))
    else $error("Stream request not answered with the current byte.");

  wr_gate_a: assert property (
    q_r.sl == S_WR && scl_fall && q_r.cnt == DATA_BITS && !start_c
    |=> q_r.addr == ($past(q_r.we2) ? page_inc($past(q_r.addr)) : $past(q_r.addr)))
    else $error("Write not gated by write enable or left its page.");

endmodule : dual_eeprom_ctrl
`default_nettype wire

// >>> verif/eeprom_host_model.sv
// Host side model: serial bus master and transmit-only clock source.
`timescale 1ns/100ps
`default_nettype none
module eeprom_host_model (
  // Clock
  input  wire logic ref_clk_i,
  // Serial bus
  input  wire logic sda_i,
  input  wire logic dev_oe_i,
  output var  logic scl_o,
  output var  logic sda_oe_o,
  // Link clock
  output var  logic link_clk_o
);
  localparam int H = 10;

  initial begin
    scl_o      = 1'b1;
    sda_oe_o   = 1'b0;
    link_clk_o = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : hold

  // Data moves only well after a clock fall has been seen, so no false start or stop is made.
  task automatic bit_x(input logic v, output logic s);
    sda_oe_o = ~v;
    hold(5);
    scl_o = 1'b1;
    hold(H);
    s = sda_i;
    scl_o = 1'b0;
    hold(5);
  endtask : bit_x

  task automatic start_c;
    sda_oe_o = 1'b0;
    hold(5);
    scl_o = 1'b1;
    hold(H);
    sda_oe_o = 1'b1;
    hold(H);
    scl_o = 1'b0;
    hold(5);
  endtask : start_c

  // The clock line is left high after a stop, which keeps the stream going.
  task automatic stop_c;
    sda_oe_o = 1'b1;
    hold(5);
    scl_o = 1'b1;
    hold(H);
    sda_oe_o = 1'b0;
    hold(H);
  endtask : stop_c

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  endtask : put_byte

  task automatic get_byte(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
    bit_x(~more, s);
  endtask : get_byte

  task automatic scl_fall;
    @(negedge ref_clk_i);
    scl_o = 1'b0;
    hold(H);
    scl_o = 1'b1;
    hold(H);
  endtask : scl_fall

  // The link clock runs only while a pulse is asked for.
  task automatic link_pulse(output logic oe);
    link_clk_o = 1'b1;
    #12;
    oe = dev_oe_i;
    #4;
    link_clk_o = 1'b0;
    #16;
  endtask : link_pulse
endmodule : eeprom_host_model
`default_nettype wire

// >>> verif/test_dual_eeprom_ctrl.sv
// Testbench of the dual mode serial EEPROM controller.
`timescale 1ns/100ps
`default_nettype none
module test_dual_eeprom_ctrl;
  import dual_eeprom_pkg::*;
  // Type field value; arbitrary, chosen for this bench.
  localparam logic [3:0] DEV = 4'h5;
  logic       ref_clk_i = 1'b0;
  logic       rst_i     = 1'b1;
  logic       wp        = 1'b0;
  logic       scl, host_oe, link_clk, dut_sda, dut_oe, tx_mode, locked;
  wire  logic sda_w;
  int         error_cnt = 0;
  int         compares  = 0;
  logic [7:0] exp_mem [0:127];

  // Open-drain line with a pull-up.
  assign sda_w = ~(host_oe | (dut_oe & ~dut_sda));
  always #5 ref_clk_i = ~ref_clk_i;

  dual_eeprom_ctrl #(.ERR_RECOVERY(1'b1), .WE_FROM_LINK(1'b0), .RECOVERY_CYC(2000), .DEV_TYPE(DEV)) i_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .transmit_only_clock_i(link_clk), .scl_i(scl), .sda_i(sda_w),
    .sda_o(dut_sda), .sda_oe_o(dut_oe), .write_protect_input_i(wp), .tx_mode_o(tx_mode), .locked_o(locked));

  eeprom_host_model i_host (.ref_clk_i(ref_clk_i), .sda_i(sda_w), .dev_oe_i(dut_oe), .scl_o(scl),
    .sda_oe_o(host_oe), .link_clk_o(link_clk));

  ////////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  // The link domain needs its clock running while reset is held.
  task automatic do_reset;
    logic d;
    @(negedge ref_clk_i);
    rst_i = 1'b1;
    fork
      begin
        repeat (8) @(negedge ref_clk_i);
        rst_i = 1'b0;
      end
      repeat (3) i_host.link_pulse(d);
    join
  endtask : do_reset

  task automatic wr_seq(input logic [6:0] base, input int n, input logic [7:0] key);
    logic       ack;
    logic [6:0] a;
    i_host.start_c();
    i_host.put_byte({DEV, 3'b101, 1'b0}, ack);
    chk("write select ack", {7'h00, ack}, 8'h01);
    i_host.put_byte({1'b0, base}, ack);
    for (int i = 0; i < n; i++) begin
      a = {base[6:3], 3'(base[2:0] + i)};
      i_host.put_byte({1'b0, a} ^ key, ack);
      if (wp) exp_mem[a] = {1'b0, a} ^ key;
    end
    i_host.stop_c();
  endtask : wr_seq

  task automatic rd_seq(input logic [6:0] a, input int n);
    logic       ack;
    logic [7:0] b;
    i_host.start_c();
    i_host.put_byte({DEV, 3'b000, 1'b0}, ack);
    i_host.put_byte({1'b0, a}, ack);
    i_host.start_c();
    i_host.put_byte({DEV, 3'b111, 1'b1}, ack);
    chk("read select ack", {7'h00, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      i_host.get_byte(i < n - 1, b);
      chk("read data", b, exp_mem[7'(a + i)]);
    end
    i_host.stop_c();
  endtask : rd_seq

  ////////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_load;
    @(negedge ref_clk_i);
    wp = 1'b1;
    i_host.scl_fall();
    chk("mode after fall", {6'h00, tx_mode, locked}, 8'h00);
    for (int p = 0; p < 16; p++) wr_seq(7'(p * 8), 8, 8'hC3);
    chk("locked", {7'h00, locked}, 8'h01);
    wr_seq(7'h13, 9, 8'h3C);
  endtask : t_load

  task automatic t_reads;
    logic       d;
    logic       ack;
    logic [7:0] b;
    fork
      rd_seq(7'h7E, 4);
      repeat (40) i_host.link_pulse(d);
    join
    @(negedge ref_clk_i);
    wp = 1'b0;
    i_host.start_c();
    i_host.put_byte({DEV, 3'b010, 1'b1}, ack);
    i_host.get_byte(1'b0, b);
    chk("current read", b, exp_mem[2]);
    i_host.stop_c();
  endtask : t_reads

  task automatic t_guard;
    logic ack;
    wr_seq(7'h20, 1, 8'hFF);
    rd_seq(7'h20, 1);
    i_host.start_c();
    i_host.put_byte({DEV ^ 4'h3, 3'b000, 1'b1}, ack);
    chk("foreign select ack", {7'h00, ack}, 8'h00);
    i_host.stop_c();
  endtask : t_guard

  // Four link edges are spent while the link side leaves reset, then the nine start pulses.
  task automatic t_stream;
    logic oe;
    for (int i = 0; i < 4; i++) i_host.link_pulse(oe);
    chk("tx mode", {6'h00, tx_mode, locked}, 8'h02);
    for (int i = 0; i < 9; i++) begin
      i_host.link_pulse(oe);
      chk("init line", {7'h00, oe}, 8'h00);
    end
    for (int k = 0; k < 129; k++) begin
      for (int j = 7; j >= 0; j--) begin
        i_host.link_pulse(oe);
        chk("tx bit", {7'h00, oe}, {7'h00, ~exp_mem[k % 128][j]});
      end
      i_host.link_pulse(oe);
      chk("tx spare bit", {7'h00, oe}, 8'h00);
    end
  endtask : t_stream

  task automatic t_recover;
    logic oe;
    i_host.scl_fall();
    chk("transition", {6'h00, tx_mode, locked}, 8'h00);
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 120; i++) i_host.link_pulse(oe);
      chk("held in transition", {7'h00, tx_mode}, 8'h00);
      if (r == 0) i_host.scl_fall();
    end
    for (int i = 0; i < 16; i++) i_host.link_pulse(oe);
    repeat (6) @(negedge ref_clk_i);
    chk("pulse expiry", {7'h00, tx_mode}, 8'h01);
    i_host.scl_fall();
    repeat (1900) @(negedge ref_clk_i);
    chk("before timeout", {7'h00, tx_mode}, 8'h00);
    repeat (200) @(negedge ref_clk_i);
    chk("after timeout", {7'h00, tx_mode}, 8'h01);
  endtask : t_recover

  ////////////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    t_load();
    t_reads();
    t_guard();
    do_reset();
    t_stream();
    t_recover();
    final_report();
  end

  // The sequence needs about 42000 core cycles.
  initial begin
    #950000;
    error_cnt++;
    final_report();
  end
endmodule : test_dual_eeprom_ctrl
`default_nettype wire
